// ### src/drsc_pkg.sv
// drsc_pkg: constants, register map and state encoding for the rail state control block
package drsc_pkg;

    // ==========================================================
    // clock and timing
    localparam int unsigned CLK_HZ          = 200_000_000;
    localparam int unsigned PWM_HZ          = 400_000;
    localparam int unsigned PSAVE_MIN_HZ    = 15_000;
    localparam int unsigned PWM_PERIOD_CYC  = CLK_HZ / PWM_HZ;
    localparam int unsigned PSAVE_MAX_CYC   = CLK_HZ / PSAVE_MIN_HZ;
    localparam int unsigned DEADTIME_CYC    = 4;
    localparam int unsigned TERM_SS_TICKS   = 128;
    localparam int unsigned OC_TRIP_TICKS   = 4;
    localparam int unsigned RAIL_SS_TICKS   = 256;

    localparam logic [15:0] PWM_PERIOD      = 16'(PWM_PERIOD_CYC);
    localparam logic [15:0] PSAVE_MAX       = 16'(PSAVE_MAX_CYC);
    localparam logic [15:0] DEADTIME        = 16'(DEADTIME_CYC);
    localparam logic [7:0]  TERM_SS         = 8'(TERM_SS_TICKS);
    localparam logic [2:0]  OC_TRIP         = 3'(OC_TRIP_TICKS);
    localparam logic [8:0]  RAIL_SS         = 9'(RAIL_SS_TICKS);

    // ==========================================================
    // register map (byte addresses)
    localparam logic [11:0] ADDR_CTRL       = 12'h000;
    localparam logic [11:0] ADDR_STATUS     = 12'h004;
    localparam logic [11:0] ADDR_IRQ_STAT   = 12'h008;
    localparam logic [11:0] ADDR_IRQ_EN     = 12'h00c;
    localparam logic [11:0] ADDR_IRQ_CLR    = 12'h010;
    localparam logic [11:0] ADDR_DUTY       = 12'h014;

    // ctrl fields
    localparam int unsigned CTRL_RAIL_EN    = 0;
    localparam int unsigned CTRL_TERM_EN    = 1;
    localparam int unsigned CTRL_FORCED_PWM_SELECT       = 2;
    localparam logic [2:0]  CTRL_RESET      = 3'h0;

    // irq event bits
    localparam int unsigned IRQ_W           = 4;
    localparam int unsigned EV_STATE        = 0;
    localparam int unsigned EV_INREG        = 1;
    localparam int unsigned EV_OC           = 2;
    localparam int unsigned EV_SUPPLY_FAIL  = 3;

    localparam logic [7:0]  DUTY_RESET      = 8'h80;

    // ==========================================================
    // operating states, one-hot
    typedef enum logic [2:0] {
        ST_OFF     = 3'b001,
        ST_RUN     = 3'b010,
        ST_STANDBY = 3'b100
    } drsc_state_e;

endpackage : drsc_pkg

// ### src/drsc_top.sv
// drsc_top: state decode, gate drive sequencing and apb registers for the memory rail
`timescale 1ns/1ps

module drsc_top
    import drsc_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        reference_settled,
    input  wire logic        control_supply_in_limits,
    input  wire logic        input_present_sense,
    input  wire logic        rail_regulated,
    input  wire logic        light_load_request,
    input  wire logic        negative_current_detect,
    input  wire logic        overcurrent_trip,
    input  wire logic        osc_tick,
    output logic             high_side_gate,
    output logic             low_side_gate,
    output logic             rail_output_enable,
    output logic             reference_buffer_output_enable,
    output logic             termination_output_enable,
    output logic             termination_full_limit,
    output logic             power_ok_output_o,
    output logic             power_ok_output_oe,
    output logic             rail_soft_start,
    output logic             reference_ok_flag,
    output logic             supply_ok_flag,
    output logic             rail_in_regulation_flag,
    output logic             irq
);

    // ==========================================================
    // helpers
    function automatic logic [15:0] inc16(input logic [15:0] v);
        inc16 = 16'(v + 16'h0001);
    endfunction : inc16

    // ==========================================================
    // apb registers
    logic [2:0]        ctrl_reg;
    logic [7:0]        duty_reg;
    logic [IRQ_W-1:0]  irq_stat_reg;
    logic [IRQ_W-1:0]  irq_en_reg;
    logic              wr_acc;
    logic              addr_ok;
    logic              rail_enable;
    logic              termination_enable;
    logic              forced_pwm_select;

    assign wr_acc  = psel && penable && pwrite;
    assign addr_ok = (paddr == ADDR_CTRL) || (paddr == ADDR_STATUS) ||
                     (paddr == ADDR_IRQ_STAT) || (paddr == ADDR_IRQ_EN) ||
                     (paddr == ADDR_IRQ_CLR) || (paddr == ADDR_DUTY);
    // zero wait state slave; unmapped addresses answer with an error
    assign pready  = 1'b1;
    assign pslverr = psel && penable && !addr_ok;

    assign rail_enable        = ctrl_reg[CTRL_RAIL_EN];
    assign termination_enable = ctrl_reg[CTRL_TERM_EN];
    assign forced_pwm_select  = ctrl_reg[CTRL_FORCED_PWM_SELECT];

    // control and duty registers written by software
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl_reg   <= CTRL_RESET;
            duty_reg   <= DUTY_RESET;
            irq_en_reg <= '0;
        end
        else if (wr_acc)
        begin
            if (paddr == ADDR_CTRL)
                ctrl_reg <= pwdata[2:0];
            if (paddr == ADDR_DUTY)
                duty_reg <= pwdata[7:0];
            if (paddr == ADDR_IRQ_EN)
                irq_en_reg <= pwdata[IRQ_W-1:0];
        end
    end

    // ==========================================================
    // reference, supply monitor and fault latch
    logic        ref_ok_reg;
    logic        supply_ok_reg;
    logic        oc_latch_reg;
    logic [2:0]  oc_cnt_reg;
    logic        rail_en_d_reg;

    // reference starts and settles only while enabled
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            ref_ok_reg <= 1'b0;
        else
            ref_ok_reg <= rail_enable && reference_settled;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            supply_ok_reg <= 1'b0;
        else
            supply_ok_reg <= ref_ok_reg && control_supply_in_limits;
    end

    // four consecutive oscillator ticks with trip latch off
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            oc_cnt_reg    <= 3'h0;
            oc_latch_reg  <= 1'b0;
            rail_en_d_reg <= 1'b0;
        end
        else
        begin
            rail_en_d_reg <= rail_enable;
            if (!rail_enable || !supply_ok_reg)
            begin
                // cycling enable or supply clears the latch
                oc_latch_reg <= 1'b0;
                oc_cnt_reg   <= 3'h0;
            end
            else if (osc_tick)
            begin
                if (!overcurrent_trip)
                    oc_cnt_reg <= 3'h0;
                else if (oc_cnt_reg == OC_TRIP - 3'h1)
                    oc_latch_reg <= 1'b1;
                else
                    oc_cnt_reg <= 3'(oc_cnt_reg + 3'h1);
            end
        end
    end

    // ==========================================================
    // state decode
    drsc_state_e state_reg;
    drsc_state_e state_next;

    // off wins whenever any condition drops, including supply failing in run
    always_comb
    begin
        state_next = ST_OFF;
        if (!supply_ok_reg || !input_present_sense || !rail_enable || oc_latch_reg)
            state_next = ST_OFF;
        else if (termination_enable)
            state_next = ST_RUN;
        else
            state_next = ST_STANDBY;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            state_reg <= ST_OFF;
        else
            state_reg <= state_next;
    end

    // ==========================================================
    // soft-starts
    logic [8:0]  rail_ss_reg;
    logic [7:0]  term_ss_reg;
    logic        term_full_reg;
    logic        psave;

    // ramp restarts on each entry from off
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            rail_ss_reg <= 9'h0;
        else if (state_reg == ST_OFF)
            rail_ss_reg <= 9'h0;
        else if (osc_tick && rail_ss_reg != RAIL_SS)
            rail_ss_reg <= 9'(rail_ss_reg + 9'h1);
    end

    // limited termination current for 128 ticks after enable
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            term_ss_reg   <= 8'h0;
            term_full_reg <= 1'b0;
        end
        else if (state_reg != ST_RUN)
        begin
            term_ss_reg   <= 8'h0;
            term_full_reg <= 1'b0;
        end
        else if (osc_tick && !term_full_reg)
        begin
            if (term_ss_reg == TERM_SS - 8'h1)
                term_full_reg <= 1'b1;
            term_ss_reg <= 8'(term_ss_reg + 8'h1);
        end
    end

    // power saving only in standby with forced-pwm select high
    assign psave = (state_reg == ST_STANDBY) && forced_pwm_select;

    // ==========================================================
    // pwm generator
    logic [15:0] cyc_reg;
    logic [15:0] period;
    logic [15:0] on_cyc;
    logic        hs_req;
    logic        hs_reg;
    logic        ls_reg;
    logic [15:0] dead_reg;
    logic        ls_block_reg;

    // fixed period normally, stretched to the 15 kHz floor at light load in power saving
    assign period = (psave && light_load_request) ? PSAVE_MAX : PWM_PERIOD;
    assign on_cyc = 16'((32'(PWM_PERIOD) * 32'(duty_reg)) >> 8);
    assign hs_req = (cyc_reg < on_cyc) && (state_reg != ST_OFF);

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            cyc_reg <= 16'h0;
        else if (state_reg == ST_OFF || inc16(cyc_reg) >= period)
            cyc_reg <= 16'h0;
        else
            cyc_reg <= inc16(cyc_reg);
    end

    // in power saving, low side blocked after negative current until next period
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            ls_block_reg <= 1'b0;
        else if (cyc_reg == 16'h0)
            ls_block_reg <= 1'b0;
        else if (psave && negative_current_detect)
            ls_block_reg <= 1'b1;
    end

    // dead time after either gate falls before the other rises, except a low gate dropped by ls_block_reg
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            hs_reg   <= 1'b0;
            ls_reg   <= 1'b0;
            dead_reg <= 16'h0;
        end
        else if (state_reg == ST_OFF)
        begin
            hs_reg   <= 1'b0;
            ls_reg   <= 1'b0;
            dead_reg <= 16'h0;
        end
        else if ((hs_reg && !hs_req) || (ls_reg && hs_req))
        begin
            hs_reg   <= 1'b0;
            ls_reg   <= 1'b0;
            dead_reg <= DEADTIME;
        end
        else if (dead_reg != 16'h0)
            dead_reg <= 16'(dead_reg - 16'h1);
        else
        begin
            // normal mode keeps low side on to sink current
            hs_reg <= hs_req;
            ls_reg <= !hs_req && !hs_reg && !ls_block_reg;
        end
    end

    // ==========================================================
    // outputs
    logic        inreg_reg;

    // regulation flag only in normal (non power-saving) operation
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            inreg_reg <= 1'b0;
        else
            inreg_reg <= (state_reg != ST_OFF) && !psave && rail_regulated &&
                         (rail_ss_reg == RAIL_SS);
    end

    assign high_side_gate                 = hs_reg;
    assign low_side_gate                  = ls_reg;
    assign rail_output_enable             = (state_reg != ST_OFF);
    assign reference_buffer_output_enable = (state_reg != ST_OFF);
    assign termination_output_enable      = (state_reg == ST_RUN);
    assign termination_full_limit         = term_full_reg;
    // power-ok pulled low while off, released otherwise
    assign power_ok_output_o              = 1'b0;
    assign power_ok_output_oe             = (state_reg == ST_OFF);
    assign rail_soft_start                = (state_reg != ST_OFF) && (rail_ss_reg != RAIL_SS);
    assign reference_ok_flag              = ref_ok_reg;
    assign supply_ok_flag                 = supply_ok_reg;
    assign rail_in_regulation_flag        = inreg_reg;

    // ==========================================================
    // interrupts: set wins over clear
    logic [IRQ_W-1:0] ev;
    logic             inreg_d_reg;
    drsc_state_e      state_d_reg;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            inreg_d_reg <= 1'b0;
            state_d_reg <= ST_OFF;
        end
        else
        begin
            inreg_d_reg <= inreg_reg;
            state_d_reg <= state_reg;
        end
    end

    always_comb
    begin
        ev                 = '0;
        ev[EV_STATE]       = (state_d_reg != state_reg);
        ev[EV_INREG]       = inreg_reg && !inreg_d_reg;
        ev[EV_OC]          = oc_latch_reg && (state_d_reg != ST_OFF) && (state_reg == ST_OFF);
        ev[EV_SUPPLY_FAIL] = (state_d_reg == ST_RUN) && (state_reg == ST_OFF) && !supply_ok_reg;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            irq_stat_reg <= '0;
        else if (wr_acc && paddr == ADDR_IRQ_CLR)
            irq_stat_reg <= (irq_stat_reg & ~pwdata[IRQ_W-1:0]) | ev;
        else
            irq_stat_reg <= irq_stat_reg | ev;
    end

    assign irq = |(irq_stat_reg & irq_en_reg);

    // ==========================================================
    // read word captured in the setup cycle: prdata comes from a flip-flop
    // and the access phase still answers with no wait state
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata <= 32'h0;
        else if (psel && !penable && !pwrite)
        begin
            case (paddr)
                ADDR_CTRL:     prdata <= {29'h0, ctrl_reg};
                ADDR_STATUS:   prdata <= {24'h0, term_full_reg, oc_latch_reg, inreg_reg,
                                          supply_ok_reg, ref_ok_reg, state_reg};
                ADDR_IRQ_STAT: prdata <= {28'h0, irq_stat_reg};
                ADDR_IRQ_EN:   prdata <= {28'h0, irq_en_reg};
                ADDR_DUTY:     prdata <= {24'h0, duty_reg};
                default:       prdata <= 32'h0;
            endcase
        end
    end

endmodule : drsc_top

// ### bench/drsc_monitor.sv
// drsc_monitor: port-level assertions for the rail state control block
`timescale 1ns/1ps
module drsc_monitor
    import drsc_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic osc_tick,
    input wire logic overcurrent_trip,
    input wire logic input_present_sense,
    input wire logic control_supply_in_limits,
    input wire logic reference_settled,
    input wire logic rail_regulated,
    input wire logic high_side_gate,
    input wire logic low_side_gate,
    input wire logic rail_output_enable,
    input wire logic termination_output_enable,
    input wire logic termination_full_limit,
    input wire logic power_ok_output_oe,
    input wire logic rail_soft_start,
    input wire logic reference_ok_flag,
    input wire logic supply_ok_flag,
    input wire logic rail_in_regulation_flag
);
    // ==========================================================
    // helper: consecutive overcurrent ticks, saturating at four
    logic [2:0] oc_cnt_reg;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            oc_cnt_reg <= 3'h0;
        else if (osc_tick)
            oc_cnt_reg <= !overcurrent_trip ? 3'h0 :
                          (oc_cnt_reg == 3'h4) ? 3'h4 : 3'(oc_cnt_reg + 3'h1);
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // ==========================================================
    // assertions
    a_gate_overlap: assert property (!(high_side_gate && low_side_gate))
        else $error("both gates high");
    a_dead_time: assert property ($fell(high_side_gate) |-> !low_side_gate [*3])
        else $error("low gate rose inside dead time");
    a_off_outputs: assert property (!rail_output_enable && $past(!rail_output_enable) |->
        !high_side_gate && !low_side_gate && power_ok_output_oe && !termination_output_enable)
        else $error("off state outputs wrong");
    a_pok_released: assert property (rail_output_enable |-> !power_ok_output_oe)
        else $error("power ok driven outside off");
    a_input_absent: assert property (!input_present_sense |-> ##[1:2] !rail_output_enable)
        else $error("input absent but not off");
    a_supply_lost: assert property (!supply_ok_flag |-> ##[1:2] !rail_output_enable)
        else $error("supply not ok but not off");
    a_ref_cause: assert property ($rose(reference_ok_flag) |-> $past(reference_settled))
        else $error("reference ok without settled reference");
    a_supply_order: assert property ($rose(supply_ok_flag) |->
        $past(reference_ok_flag) && $past(control_supply_in_limits))
        else $error("supply ok before reference ok");
    a_soft_entry: assert property ($rose(termination_output_enable) &&
        $past(!rail_output_enable) |-> rail_soft_start)
        else $error("no soft start on entry to run");
    a_term_limit: assert property ($rose(termination_output_enable) |->
        !termination_full_limit [*8])
        else $error("termination full limit too early");
    a_inreg_cause: assert property ($rose(rail_in_regulation_flag) |->
        $past(rail_regulated))
        else $error("in regulation flag without regulation");
    a_oc_latch: assert property (oc_cnt_reg == 3'h4 |-> ##[0:2] !rail_output_enable)
        else $error("overcurrent did not shut down");

    c_run_entry: cover property ($rose(termination_output_enable));
    c_term_full: cover property ($rose(termination_full_limit));
    c_oc_trip: cover property (oc_cnt_reg == 3'h4);
endmodule : drsc_monitor

bind drsc_top drsc_monitor u_drsc_monitor (.pclk, .presetn, .osc_tick, .overcurrent_trip,
    .input_present_sense, .control_supply_in_limits, .reference_settled, .rail_regulated,
    .high_side_gate, .low_side_gate, .rail_output_enable, .termination_output_enable,
    .termination_full_limit, .power_ok_output_oe, .rail_soft_start, .reference_ok_flag,
    .supply_ok_flag, .rail_in_regulation_flag);

// ### bench/drsc_far_side.sv
// drsc_far_side: oscillator tick and rail regulation model beyond the block
`timescale 1ns/1ps
module drsc_far_side #(
    parameter int TICK_DIV  = 4,
    parameter int REG_TICKS = 300
) (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic rail_output_enable,
    output logic      osc_tick,
    output logic      rail_regulated
);
    logic [7:0]  div_reg;
    logic [15:0] reg_cnt_reg;

    // ==========================================================
    // short tick divider keeps the long tick counts quick to simulate
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            div_reg <= 8'h00;
        else
            div_reg <= (div_reg == 8'(TICK_DIV - 1)) ? 8'h00 : div_reg + 8'h01;
    end
    assign osc_tick = (div_reg == 8'h00);

    // rail settles after the soft start; collapses at once when released
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            reg_cnt_reg <= 16'h0000;
        else if (!rail_output_enable)
            reg_cnt_reg <= 16'h0000;
        else if (osc_tick && reg_cnt_reg != 16'(REG_TICKS))
            reg_cnt_reg <= reg_cnt_reg + 16'h0001;
    end
    assign rail_regulated = (reg_cnt_reg == 16'(REG_TICKS));
endmodule : drsc_far_side

// ### bench/testbench.sv
// testbench: register-level scenarios for the rail state control block
`timescale 1ns/1ps
`define CHECK(a, b) begin n_tests++; if ((a) !== (b)) begin n_errors++; \
    $display("Error at %0t: got %h expected %h", $time, (a), (b)); end end
module testbench
    import drsc_pkg::*;
;
    logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rdata;
    logic        pready, pslverr, perr, osc_tick, rail_regulated;
    logic        reference_settled = 1'b0, control_supply_in_limits = 1'b1;
    logic        input_present_sense = 1'b1, light_load_request = 1'b0;
    logic        negative_current_detect = 1'b0, overcurrent_trip = 1'b0;
    logic        high_side_gate, low_side_gate, rail_output_enable, reference_buffer_output_enable;
    logic        termination_output_enable, termination_full_limit, power_ok_output_o;
    logic        power_ok_output_oe, rail_soft_start, reference_ok_flag, supply_ok_flag;
    logic        rail_in_regulation_flag, irq;
    int          n_errors = 0, n_tests = 0, cyc = 0, ls_cyc = 0, per, lh;

    drsc_top u_drsc_top (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .reference_settled, .control_supply_in_limits, .input_present_sense,
        .rail_regulated, .light_load_request, .negative_current_detect, .overcurrent_trip,
        .osc_tick, .high_side_gate, .low_side_gate, .rail_output_enable,
        .reference_buffer_output_enable, .termination_output_enable, .termination_full_limit,
        .power_ok_output_o, .power_ok_output_oe, .rail_soft_start, .reference_ok_flag,
        .supply_ok_flag, .rail_in_regulation_flag, .irq);
    drsc_far_side u_drsc_far_side (.pclk, .presetn, .rail_output_enable, .osc_tick,
        .rail_regulated);

    // ==========================================================
    // clock and free cycle counters used to time the gate edges
    always #2.5 pclk = ~pclk;
    always @(posedge pclk)
    begin
        cyc++;
        if (low_side_gate === 1'b1)
            ls_cyc++;
    end

    // ==========================================================
    // apb master: holds the request until pready is seen at an edge
    task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
        end
        while (pready !== 1'b1);
        rdata = prdata;
        perr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : xfer

    task automatic chk_rd(input logic [11:0] a, input logic [31:0] exp, input logic [31:0] m);
        xfer(1'b0, a, 32'h0);
        `CHECK(rdata & m, exp)
    endtask : chk_rd

    // period between two high gate rises, and low gate on-cycles inside it
    task automatic measure();
        int t0, l0;
        @(posedge high_side_gate);
        t0 = cyc;
        l0 = ls_cyc;
        @(posedge high_side_gate);
        per = cyc - t0;
        lh = ls_cyc - l0;
        @(posedge pclk);
    endtask : measure

    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : report_and_stop

    // watchdog sized well above the longest power-save measurement
    initial
    begin
        repeat (90000) @(posedge pclk);
        n_errors++;
        $display("Error at %0t: watchdog got %h expected %h", $time, 1'b1, 1'b0);
        report_and_stop();
    end

    // ==========================================================
    // main sequence
    initial
    begin
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        chk_rd(ADDR_CTRL, 32'(CTRL_RESET), 32'hff); // control clear
        chk_rd(ADDR_DUTY, 32'(DUTY_RESET), 32'hff); // duty default
        chk_rd(ADDR_STATUS, 32'h1, 32'hff); // off, flags clear
        `CHECK({power_ok_output_o, power_ok_output_oe, high_side_gate, low_side_gate}, 4'h4)
        xfer(1'b0, 12'h020, 32'h0);
        `CHECK({perr, rdata}, {1'b1, 32'h0}) // unmapped refused
        xfer(1'b1, ADDR_STATUS, 32'h2);
        chk_rd(ADDR_STATUS, 32'h1, 32'h7); // status read only
        xfer(1'b1, ADDR_CTRL, 32'h3);
        reference_settled <= 1'b1;
        repeat (1500) @(posedge pclk);
        chk_rd(ADDR_STATUS, 32'hba, 32'hff); // run
        measure();
        `CHECK(per, PWM_PERIOD_CYC) // fixed period
        light_load_request <= 1'b1;
        negative_current_detect <= 1'b1;
        xfer(1'b1, ADDR_CTRL, 32'h5);
        measure();
        measure();
        `CHECK(per, PSAVE_MAX_CYC) // period floor
        `CHECK(lh, 0) // low gate off
        chk_rd(ADDR_STATUS, 32'h4, 32'h7); // standby
        `CHECK({termination_output_enable, reference_buffer_output_enable}, 2'b01)
        xfer(1'b1, ADDR_CTRL, 32'h1);
        measure();
        measure();
        `CHECK(per, PWM_PERIOD_CYC) // fixed period
        `CHECK(lh != 0, 1'b1) // sinking kept
        `CHECK({termination_output_enable, power_ok_output_oe}, 2'b00)
        light_load_request <= 1'b0;
        negative_current_detect <= 1'b0;
        xfer(1'b1, ADDR_IRQ_EN, 32'h1);
        `CHECK(irq, 1'b1) // state change event
        xfer(1'b1, ADDR_IRQ_CLR, 32'hf);
        `CHECK(irq, 1'b0) // event cleared
        xfer(1'b1, ADDR_IRQ_EN, 32'h8);
        xfer(1'b1, ADDR_CTRL, 32'h3);
        repeat (20) @(posedge pclk);
        chk_rd(ADDR_STATUS, 32'h2, 32'h7); // back in run
        control_supply_in_limits <= 1'b0;
        repeat (10) @(posedge pclk);
        chk_rd(ADDR_STATUS, 32'h1, 32'h7); // supply fail
        `CHECK(irq, 1'b1) // event raised
        xfer(1'b1, ADDR_IRQ_EN, 32'h0);
        `CHECK(irq, 1'b0) // event masked
        control_supply_in_limits <= 1'b1;
        repeat (20) @(posedge pclk);
        overcurrent_trip <= 1'b1;
        repeat (30) @(posedge pclk);
        chk_rd(ADDR_STATUS, 32'h41, 32'h47); // latched off
        overcurrent_trip <= 1'b0;
        repeat (40) @(posedge pclk);
        chk_rd(ADDR_STATUS, 32'h41, 32'h47); // latch holds
        xfer(1'b1, ADDR_CTRL, 32'h2);
        xfer(1'b1, ADDR_CTRL, 32'h3);
        repeat (20) @(posedge pclk);
        chk_rd(ADDR_STATUS, 32'h02, 32'h47); // cleared by enable cycle
        input_present_sense <= 1'b0;
        repeat (5) @(posedge pclk);
        chk_rd(ADDR_STATUS, 32'h1, 32'h7); // input absent
        report_and_stop();
    end
endmodule : testbench
